// ### bench/cstb_master_model.sv
`timescale 1ns/10ps
module cstb_master_model (
    input wire logic clk, // Core clock
    output logic start_stop, // Start or stop pulse
    output logic cmd_valid, // Clock command pulse
    output logic [15:0] cmd_code, // Command code
    output logic [15:0] cmd_param, // Command parameter
    output logic buf_wr, // Buffer pair write
    output logic [1:0] buf_idx, // Buffer pair index
    output logic [15:0] buf_wdata, // Buffer pair value
    input wire logic [15:0] buf_rdata, // Buffer pair read back
    output logic tx_ready // Message taken
);
    import cstb_pkg::*;
    logic [2:0] slow = 3'h0;
    initial begin
        start_stop = 1'b0;
        cmd_valid = 1'b0;
        cmd_code = 16'h0;
        cmd_param = 16'h0;
        buf_wr = 1'b0;
        buf_idx = 2'h3;
        buf_wdata = 16'h0;
    end
    // Ready stalls in a pattern so messages are taken both promptly and late
    always @(posedge clk) begin
        slow <= slow + 3'h1;
        tx_ready <= slow[0] & slow[2];
    end
    task automatic pulse_ss();
        @(posedge clk);
        start_stop <= 1'b1;
        @(posedge clk);
        start_stop <= 1'b0;
    endtask : pulse_ss
    // Idle code and parameter show the inverse, never the last command
    task automatic cmd(input logic [15:0] p);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= CMD_CLOCK;
        cmd_param <= p;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~CMD_CLOCK;
        cmd_param <= ~p;
    endtask : cmd
    // All pairs are loaded before the set command goes out
    task automatic set_time(input logic [2:0][15:0] t);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            buf_wr <= 1'b1;
            buf_idx <= i[1:0];
            buf_wdata <= t[i];
        end
        @(posedge clk);
        buf_wr <= 1'b0;
        buf_wdata <= ~t[2];
        cmd(PAR_SET);
    endtask : set_time
    task automatic rd(input logic [1:0] i, output logic [15:0] v);
        @(posedge clk);
        buf_idx <= i;
        @(posedge clk);
        @(posedge clk);
        v = buf_rdata;
    endtask : rd
endmodule : cstb_master_model

// ### bench/cstb_top_tb.sv
`timescale 1ns/10ps
module cstb_top_tb;
    import cstb_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, pc, td, hm;
    logic [1:0] bresp, rresp, sp = 2'h0, act = 2'h0;
    logic signed [10:0] temp = 11'sh0;
    logic cm = 1'b0, tok = 1'b0, alm = 1'b0, cool = 1'b0, fit = 1'b1, inac = 1'b0, inv = 1'b0;
    logic [9:0] err = 10'h0;
    logic [3:0] cal = 4'h0;
    logic [11:0] dhi = 12'h0, dlo = 12'h0;
    logic ss, cv, bw;
    logic [15:0] cc, cp, bwd, brd, r = 16'h004E, v;
    logic [1:0] bi;
    cstb_msg_s msg;
    int n_mismatch = 0, n_checks = 0, t, mag;
    cstb_top #(.TICK_CYCLES(8)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .actual_temp(temp),
        .setpoint_idx(sp), .control_mode(cm), .temp_ok(tok), .alarm_active(alm),
        .cool_off(cool), .err_code(err), .err_action(act), .cal_state(cal), .dev_num_hi(dhi),
        .dev_num_lo(dlo), .clk_fitted(fit), .time_inaccurate(inac), .time_invalid(inv),
        .start_stop(ss), .cmd_valid(cv), .cmd_code(cc), .cmd_param(cp), .buf_wr(bw),
        .buf_idx(bi), .buf_wdata(bwd), .buf_rdata(brd), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_msg(msg), .phase_correction(pc), .temp_diag_en(td),
        .heatup_mon_en(hm));
    cstb_master_model m (.clk(clk), .start_stop(ss), .cmd_valid(cv), .cmd_code(cc),
        .cmd_param(cp), .buf_wr(bw), .buf_idx(bi), .buf_wdata(bwd), .buf_rdata(brd),
        .tx_ready(tx_ready));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ap, wp;
        ap = 1'b1;
        wp = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (ap || wp) begin
            @(posedge clk);
            if (ap && awready) begin
                ap = 1'b0;
                awvalid <= 1'b0;
            end
            if (wp && wready) begin
                wp = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        check(bresp, RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata[15:0];
        check(rresp, resp);
    endtask : rd
    task automatic get_msg();
        do @(posedge clk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
    endtask : get_msg
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    initial begin
        #(50 * 20000);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(REG_CTRL, RESP_OKAY);
        check({v[2:0], hm, td, pc}, 6'h0);
        wr(REG_CTRL, 32'h5);
        rd(REG_CTRL, RESP_OKAY);
        check({v[2:0], hm, td, pc}, 6'h2D);
        rd(8'h40, RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            @(posedge clk);
            temp <= (i == 0) ? 11'sh400 : r[10:0];
            {cool, alm, tok, cm, sp} <= r[15:10];
            m.pulse_ss();
            get_msg();
            t = temp;
            mag = (t < 0) ? -t : t;
            if (mag > 511) mag = 511;
            check(msg.id, ID_ACK);
            check(msg.data, {r[15:10], t < 0, mag[8:0]});
        end
        $display("test ack done");
        for (int c = 0; c < 16; c++) begin
            r = lfsr(r);
            @(posedge clk);
            cal <= c[3:0];
            err <= r[9:0] % 10'd1000;
            act <= r[11:10] % 2'h3;
            dhi <= r[11:0];
            dlo <= ~r[11:0];
            rd(REG_ALARM, RESP_OKAY);
            check(v, {(c == 13 || c == 15) ? CAL_ABORTED : c[3:0], act, err});
            rd(REG_DEVNUM, RESP_OKAY);
            check({rdata[27:16], rdata[11:0]}, {r[11:0], ~r[11:0]});
        end
        $display("test alarm done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {inv, inac, fit} <= i[2:0] ^ 3'h5;
            m.cmd(PAR_STAT);
            get_msg();
            check(msg, {ID_CLK_STAT, 13'h0, i[2:0] ^ 3'h5});
        end
        m.set_time({16'h630C, 16'h1E17, 16'h3A05});
        rd(REG_CLKST, RESP_OKAY);
        check(v[CST_SETTING], 1'b1);
        repeat (8) @(posedge clk);
        rd(REG_CLKST, RESP_OKAY);
        check(v[CST_SETTING], 1'b0);
        m.cmd(PAR_SNAP);
        m.rd(2'h2, v);
        check(v, 16'h630C);
        m.rd(2'h1, v);
        check(v, 16'h1E17);
        m.rd(2'h0, v);
        check(v[15:8], 8'h3A);
        // Counting runs for nine edges before the snapshot, so a stale 05 means it was lost
        check(v[7:0] == 8'h06 || v[7:0] == 8'h07, 1'b1);
        $display("test clock done");
        summarize();
    end
endmodule : cstb_top_tb

// ### hw/cstb_pkg.sv
package cstb_pkg;
    // Core clock and the one-second time base of the clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;

    // Message identifiers, commands and parameters
    localparam logic [15:0] ID_ACK = 16'h0009;
    localparam logic [15:0] ID_CLK_STAT = 16'h001D;
    localparam logic [15:0] CMD_CLOCK = 16'h0004;
    localparam logic [15:0] PAR_STAT = 16'h001E;
    localparam logic [15:0] PAR_SNAP = 16'h001F;
    localparam logic [15:0] PAR_SET = 16'h0020;

    // Acknowledgement word layout
    localparam int ACK_MAG_LSB = 0;
    localparam int ACK_SIGN = 9;
    localparam int ACK_SP_LSB = 10;
    localparam int ACK_CTRL = 12;
    localparam int ACK_TOK = 13;
    localparam int ACK_ALM = 14;
    localparam int ACK_CBLK = 15;
    localparam logic [8:0] MAG_MAX = 9'h1FF;

    // Alarm status word layout and calibration state codes
    localparam int ALM_CODE_LSB = 0;
    localparam int ALM_ACT_LSB = 10;
    localparam int ALM_CAL_LSB = 12;
    localparam logic [3:0] CAL_RESERVED = 4'hD;
    localparam logic [3:0] CAL_ABORTED = 4'hE;

    // Clock status bits
    localparam int CST_FITTED = 0;
    localparam int CST_INACC = 1;
    localparam int CST_INVALID = 2;
    localparam int CST_SETTING = 3;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACK = 8'h04;
    localparam logic [7:0] REG_ALARM = 8'h08;
    localparam logic [7:0] REG_DEVNUM = 8'h0C;
    localparam logic [7:0] REG_CLKST = 8'h10;
    localparam logic [7:0] REG_TIME = 8'h14;
    localparam int CTRL_PHASE = 0;
    localparam int CTRL_TDIAG = 1;
    localparam int CTRL_HEATMON = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Time fields, index 0 sec, 1 min, 2 hour, 3 day, 4 month, 5 year
    typedef logic [5:0][7:0] cstb_time_t;
    localparam cstb_time_t FLD_MIN = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    localparam cstb_time_t FLD_MAX = {8'h63, 8'h0C, 8'h1F, 8'h17, 8'h3B, 8'h3B};
    localparam logic [2:0] XF_LAST = 3'h5;

    typedef struct packed {
        logic [15:0] id;
        logic [15:0] data;
    } cstb_msg_s;

    typedef enum logic {XF_IDLE, XF_LOAD} cstb_xfer_e;
endpackage : cstb_pkg

// ### hw/cstb_rtc.sv
`timescale 1ns/10ps
module cstb_rtc #(
    parameter int unsigned TICK_CYCLES = cstb_pkg::TICK_CYC
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic hold, // Freeze counting while fields are loaded
    input wire logic ld_en, // Load one field this cycle
    input wire logic [2:0] ld_idx, // Field index 0 to 5
    input wire logic [7:0] ld_val, // Field value
    output cstb_pkg::cstb_time_t now // Running time
);
    import cstb_pkg::*;

    logic [31:0] div_q, div_d;
    logic tick;
    logic carry;
    cstb_time_t t_q, t_d;

    if (TICK_CYCLES < 1) begin : g_chk
        $error("TICK_CYCLES must be at least 1");
    end

    always_comb begin
        tick = (div_q == TICK_CYCLES - 1);
        div_d = tick ? 32'h0 : div_q + 32'h1;
        t_d = t_q;
        carry = tick & ~hold;
        if (ld_en) begin
            t_d[ld_idx] = ld_val;
        end else begin
            // Days roll over at 31 in every month; calendar checks live in software
            for (int i = 0; i < 6; i++) begin
                if (carry) begin
                    if (t_q[i] >= FLD_MAX[i]) begin
                        t_d[i] = FLD_MIN[i];
                    end else begin
                        t_d[i] = t_q[i] + 8'h01;
                        carry = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 32'h0;
            t_q <= FLD_MIN;
        end else begin
            div_q <= div_d;
            t_q <= t_d;
        end
    end

    assign now = t_q;
endmodule : cstb_rtc

// ### hw/cstb_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Each start or stop command queues an acknowledgement message with id 0009.
// - Ack bits 0-8 hold temperature magnitude, bit 9 its sign.
// - Ack bits 10-11 hold the last used setpoint index.
// - Ack bit 12 control mode, bit 13 temperature in band, bit 14 alarm.
// - Ack bit 15 set while zero calibration is blocked by cooling off.
// - Alarm word: error code bits 0-9, action 10-11, calibration state 12-15.
// - Calibration codes 1 to 5 report the running calibration sequence.
// - Calibration codes 6 to 12 report why calibration is blocked.
// - Code 14 means aborted; reserved code 13 is never sent.
// - Device number is two parts of three BCD digits each.
// - CAN side reaches the clock only through the time buffer.
// - Command 0004 with 001F snapshots the running time into the buffer.
// - Time moves two bytes per message through successive buffer accesses.
// - Transfer command loads the buffer into the clock, which holds its count during the load.
// - Command 0004 with 001E answers message 001D with four status bits.
// - Status bit 0 clock fitted, bit 1 time inaccurate.
// - Status bit 2 set when time is invalid after backup failure.
// - Status bit 3 set while the buffer is copied into the clock.
// - After reset phase correction, temperature diagnosis, heat-up monitoring are off.
module cstb_top #(
    parameter int unsigned TICK_CYCLES = cstb_pkg::TICK_CYC
) (
    input wire logic clk, // Core clock, 20 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic signed [10:0] actual_temp, // Actual temperature, two's complement
    input wire logic [1:0] setpoint_idx, // Last used setpoint
    input wire logic control_mode, // 1 control, 0 measurement
    input wire logic temp_ok, // Actual value inside band
    input wire logic alarm_active, // Alarm present
    input wire logic cool_off, // Zero calibration blocked by cooling off
    input wire logic [9:0] err_code, // Three-digit error code, binary
    input wire logic [1:0] err_action, // Required action code
    input wire logic [3:0] cal_state, // Calibration state from core
    input wire logic [11:0] dev_num_hi, // Device number part one, BCD
    input wire logic [11:0] dev_num_lo, // Device number part two, BCD
    input wire logic clk_fitted, // Internal clock present
    input wire logic time_inaccurate, // Compensation off, backup critical
    input wire logic time_invalid, // Fallback to last stored time
    input wire logic start_stop, // Start or stop command received, pulse
    input wire logic cmd_valid, // Clock command received, pulse
    input wire logic [15:0] cmd_code, // Command code
    input wire logic [15:0] cmd_param, // Command parameter
    input wire logic buf_wr, // Write one pair into the time buffer
    input wire logic [1:0] buf_idx, // Buffer pair index 0 to 2
    input wire logic [15:0] buf_wdata, // Pair to write, high byte upper field
    output logic [15:0] buf_rdata, // Pair at buf_idx, one cycle later
    output logic tx_valid, // Outgoing message valid
    input wire logic tx_ready, // Message handler takes the message
    output cstb_pkg::cstb_msg_s tx_msg, // Outgoing message id and word
    output logic phase_correction, // Phase correction enable
    output logic temp_diag_en, // Temperature diagnosis enable
    output logic heatup_mon_en // Heat-up time monitoring enable
);
    import cstb_pkg::*;

    logic aw_have_q, aw_have_d, w_have_q, w_have_d, awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [15:0] ack_word, alarm_word;
    logic [3:0] clk_stat, cal_code;
    logic [11:0] temp_abs;
    logic [8:0] temp_mag;
    logic ack_pend_q, ack_pend_d, stat_pend_q, stat_pend_d, tx_valid_q, tx_valid_d;
    cstb_msg_s tx_msg_q, tx_msg_d;
    cstb_time_t tbuf_q, tbuf_d, now;
    cstb_xfer_e xf_q, xf_d;
    logic [2:0] xf_idx_q, xf_idx_d;
    logic [15:0] buf_rdata_q, buf_rdata_d;
    logic cmd_snap, cmd_set, cmd_stat, tx_free, ld_en;

    // Status words, built live from the core signals
    always_comb begin
        temp_abs = actual_temp[10] ? 12'(-$signed({actual_temp[10], actual_temp}))
                                   : {1'b0, actual_temp};
        temp_mag = (temp_abs > {3'h0, MAG_MAX}) ? MAG_MAX : temp_abs[8:0];
        ack_word = 16'h0000;
        ack_word[ACK_MAG_LSB +: 9] = temp_mag;
        ack_word[ACK_SIGN] = actual_temp[10];
        ack_word[ACK_SP_LSB +: 2] = setpoint_idx;
        ack_word[ACK_CTRL] = control_mode;
        ack_word[ACK_TOK] = temp_ok;
        ack_word[ACK_ALM] = alarm_active;
        ack_word[ACK_CBLK] = cool_off;
        // Codes 0-12 and 14 pass as given; codes 13 and 15 read as aborted
        cal_code = (cal_state == CAL_RESERVED || cal_state > CAL_ABORTED) ?
                   CAL_ABORTED : cal_state;
        alarm_word = {cal_code, err_action, err_code};
        clk_stat = {xf_q == XF_LOAD, time_invalid, time_inaccurate, clk_fitted};
    end

    // Register bus slave
    always_comb begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_SLVERR;
            if (awaddr_q == REG_CTRL) begin
                bresp_d = RESP_OKAY;
                if (wstrb_q[0]) begin
                    ctrl_d = wdata_q[2:0];
                end
            end else if (awaddr_q <= REG_TIME && awaddr_q[1:0] == 2'h0) begin
                // Status registers ignore writes but answer OKAY
                bresp_d = RESP_OKAY;
            end
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: rdata_d = {29'h0, ctrl_q};
                REG_ACK: rdata_d = {16'h0, ack_word};
                REG_ALARM: rdata_d = {16'h0, alarm_word};
                REG_DEVNUM: rdata_d = {4'h0, dev_num_hi, 4'h0, dev_num_lo};
                REG_CLKST: rdata_d = {28'h0, clk_stat};
                REG_TIME: rdata_d = {8'h00, now[2], now[1], now[0]};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
            ctrl_q <= CTRL_RST;
        end else begin
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Message side: time buffer, clock transfer and outgoing messages
    always_comb begin
        cmd_snap = cmd_valid && cmd_code == CMD_CLOCK && cmd_param == PAR_SNAP;
        cmd_set = cmd_valid && cmd_code == CMD_CLOCK && cmd_param == PAR_SET;
        cmd_stat = cmd_valid && cmd_code == CMD_CLOCK && cmd_param == PAR_STAT;
        tbuf_d = tbuf_q;
        xf_d = xf_q;
        xf_idx_d = xf_idx_q;
        ld_en = 1'b0;
        // Buffer is frozen during a transfer so the clock gets one consistent image
        case (xf_q)
            XF_IDLE: begin
                if (cmd_set) begin
                    xf_d = XF_LOAD;
                    xf_idx_d = 3'h0;
                end else if (cmd_snap) begin
                    tbuf_d = now;
                end else if (buf_wr && buf_idx != 2'h3) begin
                    tbuf_d[{buf_idx, 1'b0}] = buf_wdata[7:0];
                    tbuf_d[{buf_idx, 1'b1}] = buf_wdata[15:8];
                end
            end
            XF_LOAD: begin
                ld_en = 1'b1;
                xf_idx_d = xf_idx_q + 3'h1;
                if (xf_idx_q == XF_LAST) begin
                    xf_d = XF_IDLE;
                end
            end
            default: xf_d = XF_IDLE;
        endcase
        buf_rdata_d = (buf_idx == 2'h3) ? 16'h0000
                    : {tbuf_q[{buf_idx, 1'b1}], tbuf_q[{buf_idx, 1'b0}]};
        // Pending flags: a new request in the send cycle is merged, never lost
        tx_free = !tx_valid_q || tx_ready;
        ack_pend_d = ack_pend_q || start_stop;
        stat_pend_d = stat_pend_q || cmd_stat;
        tx_valid_d = tx_valid_q && !tx_ready;
        tx_msg_d = tx_msg_q;
        if (tx_free && ack_pend_d) begin
            tx_valid_d = 1'b1;
            tx_msg_d = '{id: ID_ACK, data: ack_word};
            ack_pend_d = 1'b0;
        end else if (tx_free && stat_pend_d) begin
            tx_valid_d = 1'b1;
            tx_msg_d = '{id: ID_CLK_STAT, data: {12'h000, clk_stat}};
            stat_pend_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tbuf_q <= FLD_MIN;
            xf_q <= XF_IDLE;
            xf_idx_q <= 3'h0;
            buf_rdata_q <= 16'h0000;
            ack_pend_q <= 1'b0;
            stat_pend_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_msg_q <= '0;
        end else begin
            tbuf_q <= tbuf_d;
            xf_q <= xf_d;
            xf_idx_q <= xf_idx_d;
            buf_rdata_q <= buf_rdata_d;
            ack_pend_q <= ack_pend_d;
            stat_pend_q <= stat_pend_d;
            tx_valid_q <= tx_valid_d;
            tx_msg_q <= tx_msg_d;
        end
    end

    cstb_rtc #(.TICK_CYCLES(TICK_CYCLES)) u_rtc (
        .clk(clk),
        .rst(rst),
        .hold(xf_q == XF_LOAD),
        .ld_en(ld_en),
        .ld_idx(xf_idx_q),
        .ld_val(tbuf_q[xf_idx_q]),
        .now(now)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign buf_rdata = buf_rdata_q;
    assign tx_valid = tx_valid_q;
    assign tx_msg = tx_msg_q;
    assign phase_correction = ctrl_q[CTRL_PHASE];
    assign temp_diag_en = ctrl_q[CTRL_TDIAG];
    assign heatup_mon_en = ctrl_q[CTRL_HEATMON];

    sequence xf_busy_s;
        clk_stat[CST_SETTING] [*6];
    endsequence

    sequence xf_done_s;
        !clk_stat[CST_SETTING];
    endsequence

    ack_queued_a: assert property (@(posedge clk) disable iff (rst)
        start_stop |=> ack_pend_q || (tx_valid_q && tx_msg_q.id == ID_ACK))
        else $error("start or stop did not queue an acknowledgement");
    ack_temp_a: assert property (@(posedge clk) disable iff (rst)
        (actual_temp > -11'sd512 && actual_temp < 11'sd512) |->
        ack_word[8:0] == 9'(actual_temp < 0 ? -actual_temp : actual_temp) &&
        ack_word[ACK_SIGN] == (actual_temp < 0))
        else $error("acknowledgement temperature field wrong");
    ack_status_a: assert property (@(posedge clk) disable iff (rst)
        ack_word[15:10] == {cool_off, alarm_active, temp_ok, control_mode, setpoint_idx})
        else $error("acknowledgement status bits wrong");
    cal_reserved_a: assert property (@(posedge clk) disable iff (rst)
        alarm_word[15:12] != CAL_RESERVED &&
        (cal_state > 4'hC || alarm_word[15:12] == cal_state))
        else $error("calibration state code wrong");
    snap_copy_a: assert property (@(posedge clk) disable iff (rst)
        (cmd_snap && xf_q == XF_IDLE && !cmd_set) |=> tbuf_q == $past(now))
        else $error("time snapshot not taken");
    xfer_flag_a: assert property (@(posedge clk) disable iff (rst)
        (cmd_set && xf_q == XF_IDLE) |=> xf_busy_s ##1 xf_done_s)
        else $error("setting-clock flag length wrong");
    xfer_load_a: assert property (@(posedge clk) disable iff (rst)
        (cmd_set && xf_q == XF_IDLE) |-> ##7 now[5:3] == $past(tbuf_q[5:3], 6))
        else $error("clock not loaded from buffer");
    stat_reply_a: assert property (@(posedge clk) disable iff (rst)
        (tx_valid_q && tx_msg_q.id == ID_CLK_STAT) |-> tx_msg_q.data[15:4] == 12'h000)
        else $error("clock status reply has stray bits");
    cfg_reset_a: assert property (@(posedge clk)
        $past(rst) |-> !phase_correction && !temp_diag_en && !heatup_mon_en)
        else $error("configuration not cleared by reset");
endmodule : cstb_top
